// file: src/ufmf_params.svh
// Offsets, field positions, reset values and frame constants of the filter control block
`ifndef UFMF_PARAMS_SVH
`define UFMF_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define UFMF_IDX_BUCKET 10'h31A
`define UFMF_IDX_UC 10'h320
`define UFMF_IDX_MC 10'h324
`define UFMF_IDX_VID 10'h328
`define UFMF_IDX_MAC 10'h330
`define UFMF_ADDR_W 12
`define UFMF_IDX_MSB 11
`define UFMF_IDX_LSB 2

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define UFMF_BUCKET_W 10
`define UFMF_PORTS 7
`define UFMF_FWD_EN_BIT 31
`define UFMF_MAC_ALT_BIT 7
`define UFMF_MAC_LEN_BIT 3
`define UFMF_MAC_FC_BIT 1
`define UFMF_MAC_AGGR_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UFMF_RST_BUCKET 10'h000
`define UFMF_RST_MASK 7'h00
`define UFMF_RST_EN 1'h0
`define UFMF_RST_MAC 8'h04
`define UFMF_RST_RDATA 32'h0000_0000

// ----------------------------------------------------------------
// Frame constants
// ----------------------------------------------------------------
`define UFMF_FC_ETYPE 16'h8808
`define UFMF_FC_DA 48'h0180_C200_0001
`define UFMF_LEN_LIMIT 16'h05DC

`endif

// file: src/ufmf_pkg.sv
// Types shared by the filter control block
`default_nettype none
package ufmf_pkg;

   // ----------------------------------------------------------------
   // Frame classification carriers
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      UFMF_CAT_NONE = 4'h1,
      UFMF_CAT_VID = 4'h2,
      UFMF_CAT_UC = 4'h4,
      UFMF_CAT_MC = 4'h8
   } ufmf_cat_t;

   typedef struct packed {
      logic valid;
      logic unk_vid;
      logic unk_uc;
      logic unk_mc;
      logic [15:0] ethertype;
      logic [47:0] da;
      logic [15:0] type_len;
      logic [15:0] act_len;
   } ufmf_frame_t;

   typedef struct packed {
      logic valid;
      ufmf_cat_t cat;
      logic [6:0] mask;
      logic drop;
   } ufmf_verdict_t;

   typedef struct packed {
      logic en;
      logic [6:0] mask;
   } ufmf_fwd_t;

   // ----------------------------------------------------------------
   // Whole state of the block
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [9:0] bucket;
      ufmf_fwd_t uc;
      ufmf_fwd_t mc;
      ufmf_fwd_t vid;
      logic [7:0] mac;
      logic wait_req;
      logic [31:0] rdata;
      ufmf_verdict_t verdict;
      logic [6:0] alt_bo;
      logic [6:0] aggr_bo;
   } ufmf_state_t;

endpackage

`default_nettype wire

// file: src/ufmf_ctrl.sv
// Unknown forwarding, lookup index and MAC frame filter control with Avalon-MM slave
`timescale 1ns/1ns
`default_nettype none
`include "ufmf_params.svh"

module ufmf_ctrl (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [`UFMF_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic lut_access_i,
   input wire logic [`UFMF_BUCKET_W-1:0] lut_bucket_i,
   input wire ufmf_pkg::ufmf_frame_t frame_i,
   output ufmf_pkg::ufmf_verdict_t verdict_o,
   input wire logic [`UFMF_PORTS-1:0] half_duplex_i,
   output logic [`UFMF_PORTS-1:0] alt_backoff_o,
   output logic [`UFMF_PORTS-1:0] aggr_backoff_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ufmf_pkg::ufmf_state_t state_ff;
   ufmf_pkg::ufmf_state_t nxt_state;

   logic req;
   logic [`UFMF_IDX_MSB-`UFMF_IDX_LSB:0] idx;
   logic aligned;
   logic [31:0] rd_word;
   logic [31:0] wr_mask;
   ufmf_pkg::ufmf_fwd_t sel;
   ufmf_pkg::ufmf_cat_t cat;
   logic et_hit;
   logic da_hit;
   logic fc_drop;
   logic len_drop;

   assign req = avs_read_i | avs_write_i;
   assign idx = avs_address_i[`UFMF_IDX_MSB:`UFMF_IDX_LSB];
   assign aligned = (avs_address_i[`UFMF_IDX_LSB-1:0] == 2'h0);
   assign wr_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                     {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // Reserved bits and unmapped words read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (aligned) begin
         case (idx)
            `UFMF_IDX_BUCKET: begin
               rd_word = {22'h00_0000, state_ff.bucket};
            end
            `UFMF_IDX_UC: begin
               rd_word = {state_ff.uc.en, 24'h00_0000, state_ff.uc.mask};
            end
            `UFMF_IDX_MC: begin
               rd_word = {state_ff.mc.en, 24'h00_0000, state_ff.mc.mask};
            end
            `UFMF_IDX_VID: begin
               rd_word = {state_ff.vid.en, 24'h00_0000, state_ff.vid.mask};
            end
            `UFMF_IDX_MAC: begin
               rd_word = {24'h00_0000, state_ff.mac};
            end
            default: begin
               rd_word = 32'h0000_0000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Frame classification
   // ----------------------------------------------------------------
   // Highest-ranked category wins; lower categories are not consulted
   always_comb begin
      if (frame_i.unk_vid) begin
         cat = ufmf_pkg::UFMF_CAT_VID;
         sel = state_ff.vid;
      end else if (frame_i.unk_uc) begin
         cat = ufmf_pkg::UFMF_CAT_UC;
         sel = state_ff.uc;
      end else if (frame_i.unk_mc) begin
         cat = ufmf_pkg::UFMF_CAT_MC;
         sel = state_ff.mc;
      end else begin
         cat = ufmf_pkg::UFMF_CAT_NONE;
         sel = '0;
      end
   end

   assign et_hit = (frame_i.ethertype == `UFMF_FC_ETYPE);
   assign da_hit = (frame_i.da == `UFMF_FC_DA);
   assign fc_drop = state_ff.mac[`UFMF_MAC_FC_BIT] ? (et_hit | da_hit) : (et_hit & da_hit);
   assign len_drop = state_ff.mac[`UFMF_MAC_LEN_BIT]
                     && (frame_i.type_len < `UFMF_LEN_LIMIT)
                     && (frame_i.act_len != frame_i.type_len);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      if (ce_i) begin
         if (lut_access_i) begin
            nxt_state.bucket = lut_bucket_i;
         end
         // Answer one cycle after the request; write lands on the edge that sees wait low
         if (req && state_ff.wait_req) begin
            nxt_state.wait_req = 1'b0;
            nxt_state.rdata = avs_read_i ? rd_word : 32'h0000_0000;
         end else if (req) begin
            nxt_state.wait_req = 1'b1;
            if (avs_write_i && aligned) begin
               case (idx)
                  `UFMF_IDX_UC: begin
                     nxt_state.uc.en = avs_byteenable_i[3]
                        ? avs_writedata_i[`UFMF_FWD_EN_BIT] : state_ff.uc.en;
                     nxt_state.uc.mask = (avs_writedata_i[6:0] & wr_mask[6:0])
                        | (state_ff.uc.mask & ~wr_mask[6:0]);
                  end
                  `UFMF_IDX_MC: begin
                     nxt_state.mc.en = avs_byteenable_i[3]
                        ? avs_writedata_i[`UFMF_FWD_EN_BIT] : state_ff.mc.en;
                     nxt_state.mc.mask = (avs_writedata_i[6:0] & wr_mask[6:0])
                        | (state_ff.mc.mask & ~wr_mask[6:0]);
                  end
                  `UFMF_IDX_VID: begin
                     nxt_state.vid.en = avs_byteenable_i[3]
                        ? avs_writedata_i[`UFMF_FWD_EN_BIT] : state_ff.vid.en;
                     nxt_state.vid.mask = (avs_writedata_i[6:0] & wr_mask[6:0])
                        | (state_ff.vid.mask & ~wr_mask[6:0]);
                  end
                  `UFMF_IDX_MAC: begin
                     nxt_state.mac = (avs_writedata_i[7:0] & wr_mask[7:0])
                        | (state_ff.mac & ~wr_mask[7:0]);
                  end
                  default: begin
                     nxt_state.mac = state_ff.mac;
                  end
               endcase
            end
         end else begin
            nxt_state.wait_req = 1'b1;
         end
         nxt_state.verdict.valid = frame_i.valid;
         nxt_state.verdict.cat = cat;
         // A disabled category forwards nowhere, not to the next category
         nxt_state.verdict.mask = (frame_i.valid && sel.en) ? sel.mask : 7'h00;
         nxt_state.verdict.drop = frame_i.valid && (fc_drop || len_drop);
         // Back-off tweaks apply only to half-duplex ports
         nxt_state.alt_bo = half_duplex_i
            & {`UFMF_PORTS{state_ff.mac[`UFMF_MAC_ALT_BIT]}};
         nxt_state.aggr_bo = half_duplex_i
            & {`UFMF_PORTS{state_ff.mac[`UFMF_MAC_AGGR_BIT]}};
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff.bucket <= `UFMF_RST_BUCKET;
         state_ff.uc <= {`UFMF_RST_EN, `UFMF_RST_MASK};
         state_ff.mc <= {`UFMF_RST_EN, `UFMF_RST_MASK};
         state_ff.vid <= {`UFMF_RST_EN, `UFMF_RST_MASK};
         state_ff.mac <= `UFMF_RST_MAC;
         state_ff.wait_req <= 1'b1;
         state_ff.rdata <= `UFMF_RST_RDATA;
         state_ff.verdict <= {1'b0, ufmf_pkg::UFMF_CAT_NONE, `UFMF_RST_MASK, 1'b0};
         state_ff.alt_bo <= `UFMF_RST_MASK;
         state_ff.aggr_bo <= `UFMF_RST_MASK;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign avs_readdata_o = state_ff.rdata;
   assign avs_waitrequest_o = state_ff.wait_req;
   assign verdict_o = state_ff.verdict;
   assign alt_backoff_o = state_ff.alt_bo;
   assign aggr_backoff_o = state_ff.aggr_bo;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   logic fv;
   assign fv = ce_i && frame_i.valid;

   property p_bucket;
      ce_i && lut_access_i |=> state_ff.bucket == $past(lut_bucket_i);
   endproperty
   a_bucket: assert property (p_bucket) else $error("bucket not recorded");

   property p_rank;
      fv && frame_i.unk_vid |=> verdict_o.cat == ufmf_pkg::UFMF_CAT_VID;
   endproperty
   a_rank: assert property (p_rank) else $error("vlan category not ranked first");

   property p_uc_off;
      fv && !frame_i.unk_vid && frame_i.unk_uc && !state_ff.uc.en |=> verdict_o.mask == 7'h00;
   endproperty
   a_uc_off: assert property (p_uc_off) else $error("disabled unicast forwarded");

   property p_uc_mask;
      fv && !frame_i.unk_vid && frame_i.unk_uc && state_ff.uc.en
         |=> verdict_o.mask == $past(state_ff.uc.mask);
   endproperty
   a_uc_mask: assert property (p_uc_mask) else $error("unicast mask wrong");

   property p_mc;
      fv && !frame_i.unk_vid && !frame_i.unk_uc && frame_i.unk_mc
         |=> verdict_o.mask == ($past(state_ff.mc.en) ? $past(state_ff.mc.mask) : 7'h00);
   endproperty
   a_mc: assert property (p_mc) else $error("multicast mask wrong");

   property p_vid;
      fv && frame_i.unk_vid
         |=> verdict_o.mask == ($past(state_ff.vid.en) ? $past(state_ff.vid.mask) : 7'h00);
   endproperty
   a_vid: assert property (p_vid) else $error("vlan mask wrong");

   property p_fc_either;
      fv && state_ff.mac[`UFMF_MAC_FC_BIT] && (et_hit || da_hit) |=> verdict_o.drop;
   endproperty
   a_fc_either: assert property (p_fc_either) else $error("either-match not dropped");

   property p_fc_both;
      fv && !state_ff.mac[`UFMF_MAC_FC_BIT] && !len_drop
         |=> verdict_o.drop == $past(et_hit && da_hit);
   endproperty
   a_fc_both: assert property (p_fc_both) else $error("both-match drop wrong");

   property p_len;
      fv && !fc_drop |=> verdict_o.drop == $past(len_drop);
   endproperty
   a_len: assert property (p_len) else $error("length check wrong");

   property p_backoff;
      ce_i |=> alt_backoff_o
         == ($past(half_duplex_i) & {`UFMF_PORTS{$past(state_ff.mac[`UFMF_MAC_ALT_BIT])}});
   endproperty
   a_backoff: assert property (p_backoff) else $error("alternate back-off wrong");

   property p_aggr;
      ce_i |=> aggr_backoff_o
         == ($past(half_duplex_i) & {`UFMF_PORTS{$past(state_ff.mac[`UFMF_MAC_AGGR_BIT])}});
   endproperty
   a_aggr: assert property (p_aggr) else $error("aggressive back-off on full duplex");

   property p_wait;
      ce_i && req && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_wait: assert property (p_wait) else $error("bus answer late");

   property p_wait_back;
      ce_i && req && !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_wait_back: assert property (p_wait_back) else $error("bus answer stood too long");

   // Clock enable low must freeze everything, bus answer included
   property p_freeze;
      !ce_i |=> $stable(state_ff);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with enable low");

   property p_bucket_hold;
      ce_i && !lut_access_i |=> $stable(state_ff.bucket);
   endproperty
   a_bucket_hold: assert property (p_bucket_hold) else $error("bucket changed");

   property p_uc_rank;
      fv && !frame_i.unk_vid && frame_i.unk_uc |=> verdict_o.cat == ufmf_pkg::UFMF_CAT_UC;
   endproperty
   a_uc_rank: assert property (p_uc_rank) else $error("unicast not ranked second");

   property p_mc_mask;
      fv && !frame_i.unk_vid && !frame_i.unk_uc && frame_i.unk_mc && state_ff.mc.en
         |=> verdict_o.mask == $past(state_ff.mc.mask);
   endproperty
   a_mc_mask: assert property (p_mc_mask) else $error("multicast mask lost");

   property p_vid_mask;
      fv && frame_i.unk_vid && state_ff.vid.en |=> verdict_o.mask == $past(state_ff.vid.mask);
   endproperty
   a_vid_mask: assert property (p_vid_mask) else $error("vlan mask lost");

   property p_ones;
      fv && sel.en && (sel.mask == {`UFMF_PORTS{1'b1}})
         |=> verdict_o.mask == {`UFMF_PORTS{1'b1}};
   endproperty
   a_ones: assert property (p_ones) else $error("all-ones mask not all ports");

   property p_no_cat;
      fv && !frame_i.unk_vid && !frame_i.unk_uc && !frame_i.unk_mc
         |=> verdict_o.cat == ufmf_pkg::UFMF_CAT_NONE && verdict_o.mask == 7'h00;
   endproperty
   a_no_cat: assert property (p_no_cat) else $error("known frame forwarded");

   property p_idle;
      ce_i && !frame_i.valid
         |=> !verdict_o.valid && !verdict_o.drop && verdict_o.mask == 7'h00;
   endproperty
   a_idle: assert property (p_idle) else $error("verdict without frame");

   property p_len_off;
      fv && !state_ff.mac[`UFMF_MAC_LEN_BIT] && !fc_drop |=> !verdict_o.drop;
   endproperty
   a_len_off: assert property (p_len_off) else $error("length checked while off");

   c_write: cover property (ce_i && avs_write_i && !avs_waitrequest_o);
   c_read: cover property (ce_i && avs_read_i && !avs_waitrequest_o);
   c_multi: cover property (fv && frame_i.unk_vid && frame_i.unk_uc && frame_i.unk_mc);
   c_drop: cover property (verdict_o.valid && verdict_o.drop);
   c_ce_low: cover property (!ce_i && lut_access_i);

endmodule

`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the filter control block
`timescale 1ns/1ns
`default_nettype none
`include "ufmf_params.svh"

module tb_top;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam logic [11:0] A_BKT = {`UFMF_IDX_BUCKET, 2'h0};
   localparam logic [11:0] A_UC = {`UFMF_IDX_UC, 2'h0};
   localparam logic [11:0] A_MC = {`UFMF_IDX_MC, 2'h0};
   localparam logic [11:0] A_VID = {`UFMF_IDX_VID, 2'h0};
   localparam logic [11:0] A_MAC = {`UFMF_IDX_MAC, 2'h0};
   localparam ufmf_pkg::ufmf_cat_t C_NO = ufmf_pkg::UFMF_CAT_NONE;
   localparam ufmf_pkg::ufmf_cat_t C_VID = ufmf_pkg::UFMF_CAT_VID;
   localparam ufmf_pkg::ufmf_cat_t C_UC = ufmf_pkg::UFMF_CAT_UC;
   localparam ufmf_pkg::ufmf_cat_t C_MC = ufmf_pkg::UFMF_CAT_MC;
   localparam logic [47:0] FC_DA = 48'h0180_C200_0001;
   logic clock_i = 1'h0;
   logic resetn_i = 1'h0;
   logic ce = 1'h1;
   logic [11:0] addr = 12'h000;
   logic rd_en = 1'h0;
   logic wr_en = 1'h0;
   logic [3:0] be = 4'hF;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic waitreq;
   logic lut_acc = 1'h0;
   logic [9:0] lut_bkt = 10'h000;
   ufmf_pkg::ufmf_frame_t frame = '0;
   ufmf_pkg::ufmf_verdict_t verdict;
   logic [6:0] hdx = 7'h00;
   logic [6:0] alt_bo;
   logic [6:0] aggr_bo;
   logic [31:0] got;
   int miscompares = 0;
   int n_compared = 0;

   always #25 clock_i = ~clock_i;

   ufmf_ctrl uut (
      .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce), .avs_address_i(addr),
      .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_byteenable_i(be),
      .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
      .lut_access_i(lut_acc), .lut_bucket_i(lut_bkt), .frame_i(frame),
      .verdict_o(verdict), .half_duplex_i(hdx), .alt_backoff_o(alt_bo),
      .aggr_backoff_o(aggr_bo)
   );

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic print_verdict();
      if (miscompares == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_vd(input ufmf_pkg::ufmf_verdict_t g, input ufmf_pkg::ufmf_verdict_t e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] b);
      int n;
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      be <= b;
      wr_en <= w;
      rd_en <= ~w;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (waitreq !== 1'h0 && n < 20);
      if (waitreq !== 1'h0) begin
         miscompares++;
         print_verdict();
      end
      got = rdata;
      wr_en <= 1'h0;
      rd_en <= 1'h0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'h1, a, d, 4'hF);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0000_0000, 4'hF);
      chk_word(got, e);
   endtask

   task automatic lut(input logic [9:0] v);
      @(posedge clock_i);
      lut_acc <= 1'h1;
      lut_bkt <= v;
      @(posedge clock_i);
      lut_acc <= 1'h0;
   endtask

   // Verdict is registered: taken at one edge, looked at before the next
   task automatic send(input logic [2:0] u, input logic [15:0] et, input logic [47:0] da,
      input logic [15:0] tl, input logic [15:0] al, input ufmf_pkg::ufmf_cat_t c,
      input logic [6:0] m, input logic d);
      ufmf_pkg::ufmf_verdict_t e;
      e = '{valid: 1'h1, cat: c, mask: m, drop: d};
      @(posedge clock_i);
      frame <= '{valid: 1'h1, unk_vid: u[2], unk_uc: u[1], unk_mc: u[0], ethertype: et,
         da: da, type_len: tl, act_len: al};
      @(posedge clock_i);
      frame <= '0;
      @(negedge clock_i);
      chk_vd(verdict, e);
   endtask

   // Type field above the length limit keeps the length check out of the way
   task automatic cat(input logic [2:0] u, input ufmf_pkg::ufmf_cat_t c, input logic [6:0] m);
      send(u, 16'h0800, 48'h0, 16'h0600, 16'h0040, c, m, 1'h0);
   endtask

   task automatic drp(input logic [15:0] et, input logic [47:0] da, input logic [15:0] tl,
      input logic [15:0] al, input logic d);
      send(3'h0, et, da, tl, al, C_NO, 7'h00, d);
   endtask

   task automatic chk_bo(input logic [6:0] ea, input logic [6:0] eg);
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      chk_word({25'h0, alt_bo}, {25'h0, ea});
      chk_word({25'h0, aggr_bo}, {25'h0, eg});
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clock_i);
      resetn_i <= 1'h1;
      rd_chk(A_BKT, 32'h0000_0000);
      rd_chk(A_UC, 32'h0000_0000);
      rd_chk(A_MC, 32'h0000_0000);
      rd_chk(A_VID, 32'h0000_0000);
      rd_chk(A_MAC, 32'h0000_0004);
      rd_chk(12'h004, 32'h0000_0000);
      wr(A_UC, 32'hFFFF_FFFF);
      rd_chk(A_UC, 32'h8000_007F);
      wr(A_MC, 32'hFFFF_FFFF);
      rd_chk(A_MC, 32'h8000_007F);
      wr(A_VID, 32'hFFFF_FFFF);
      rd_chk(A_VID, 32'h8000_007F);
      bus(1'h1, A_UC, 32'h0000_0000, 4'h8);
      rd_chk(A_UC, 32'h0000_007F);
      // Misaligned accesses are refused: write ignored, read gives zero
      wr(A_UC + 12'h001, 32'h8000_0000);
      rd_chk(A_UC + 12'h001, 32'h0000_0000);
      rd_chk(A_UC, 32'h0000_007F);
      wr(A_BKT, 32'hFFFF_FFFF);
      rd_chk(A_BKT, 32'h0000_0000);
      lut(10'h3FF);
      rd_chk(A_BKT, 32'h0000_03FF);
      lut(10'h155);
      rd_chk(A_BKT, 32'h0000_0155);
      // An access seen while the clock enable is low must not be recorded
      ce <= 1'h0;
      lut(10'h2AA);
      ce <= 1'h1;
      rd_chk(A_BKT, 32'h0000_0155);
      wr(A_UC, 32'h8000_0055);
      wr(A_MC, 32'h8000_002A);
      wr(A_VID, 32'h8000_007F);
      wr(A_MAC, 32'h0000_0000);
      cat(3'h7, C_VID, 7'h7F);
      cat(3'h3, C_UC, 7'h55);
      cat(3'h1, C_MC, 7'h2A);
      cat(3'h0, C_NO, 7'h00);
      wr(A_VID, 32'h0000_007F);
      cat(3'h6, C_VID, 7'h00);
      wr(A_UC, 32'h0000_0055);
      cat(3'h3, C_UC, 7'h00);
      wr(A_MC, 32'h0000_002A);
      cat(3'h1, C_MC, 7'h00);
      wr(A_MC, 32'h8000_0000);
      cat(3'h1, C_MC, 7'h00);
      wr(A_MAC, 32'h0000_0002);
      drp(16'h8808, 48'h0, 16'h0600, 16'h0040, 1'h1);
      drp(16'h0800, FC_DA, 16'h0600, 16'h0040, 1'h1);
      drp(16'h8808, FC_DA, 16'h0600, 16'h0040, 1'h1);
      drp(16'h0800, 48'h0, 16'h0600, 16'h0040, 1'h0);
      wr(A_MAC, 32'h0000_0000);
      drp(16'h8808, 48'h0, 16'h0600, 16'h0040, 1'h0);
      drp(16'h0800, FC_DA, 16'h0600, 16'h0040, 1'h0);
      drp(16'h8808, FC_DA, 16'h0600, 16'h0040, 1'h1);
      drp(16'h0800, 48'h0, 16'h0064, 16'h0063, 1'h0);
      wr(A_MAC, 32'h0000_0008);
      drp(16'h0800, 48'h0, 16'h0064, 16'h0063, 1'h1);
      drp(16'h0800, 48'h0, 16'h0064, 16'h0064, 1'h0);
      drp(16'h0800, 48'h0, 16'h05DB, 16'h0010, 1'h1);
      drp(16'h0800, 48'h0, 16'h05DC, 16'h0010, 1'h0);
      hdx <= 7'h5A;
      // Software sets alternate back-off together with aggressive back-off, then each one alone
      wr(A_MAC, 32'h0000_0081);
      rd_chk(A_MAC, 32'h0000_0081);
      chk_bo(7'h5A, 7'h5A);
      wr(A_MAC, 32'h0000_0080);
      chk_bo(7'h5A, 7'h00);
      wr(A_MAC, 32'h0000_0001);
      chk_bo(7'h00, 7'h5A);
      print_verdict();
   end
endmodule
`default_nettype wire
